// [dv/arisq_host.sv]
`timescale 1ns/10ps
module arisq_host #(parameter PWR_WAIT = 8, PULSE = 40) (
   input wire clk,
   output logic reset_pin = 0, reference_config_pin = 1, serial_port_select = 0);
   // Strap fixed and clock running first; power-on wait shortened to keep runs short
   task hw_reset(input logic lvl);
      reference_config_pin = lvl;
      repeat (PWR_WAIT) @(negedge clk);
      reset_pin = 1;
      repeat (PULSE) @(negedge clk);
      reset_pin = 0; // select stays low here
   endtask
endmodule

// [dv/arisq_monitor.sv]
`timescale 1ns/10ps
module arisq_monitor #(parameter CAL_CYCLES = 20, FUSE_CYCLES = 4) (
   input wire clk, rst, reset_pin, wr_en, busy, fuse_load, cal_run, defaults_apply, write_refused,
   input wire [7:0] wr_addr, wr_data);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Figures match the counts used in simulation (fuse 4, calibration shortened to 20)
   a_pin_reset: assert property (reset_pin |=> busy && defaults_apply) else $error("pin");
   a_fuse_start: assert property ($fell(reset_pin) |-> ##[1:4] fuse_load) else $error("fuse");
   a_fuse_len: assert property ($rose(fuse_load) |-> fuse_load[*4] ##1 !fuse_load) else $error("fuse");
   a_cal_next: assert property ($fell(fuse_load) && !defaults_apply |-> ##[0:1] cal_run) else $error("cal");
   a_cal_len: assert property ($rose(cal_run) |-> ##[19:21] $fell(cal_run)) else $error("cal");
   a_busy_end: assert property ($fell(cal_run) && !defaults_apply |-> ##[0:2] !busy) else $error("busy");
   a_refuse: assert property (wr_en && busy |=> write_refused) else $error("refuse");
   a_soft_reset: assert property (wr_en && !busy && wr_data[0] && wr_addr == 8'h00
      |-> ##[1:3] defaults_apply) else $error("soft");
   c_cal: cover property ($rose(cal_run));
   c_refuse: cover property (write_refused);
   c_idle: cover property ($fell(busy));
endmodule
bind arisq_sequencer arisq_monitor #(.CAL_CYCLES(CAL_CYCLES), .FUSE_CYCLES(FUSE_CYCLES)) mon_u (.*);

// [dv/test_arisq_sequencer.sv]
`timescale 1ns/10ps
module test_arisq_sequencer;
   logic clk = 0, rst = 1, wr_en = 0, rd_en = 0;
   logic [7:0] wr_addr = '0, wr_data = '0, rd_addr = '0;
   wire reset_pin, reference_config_pin, serial_port_select, busy, fuse_load, cal_run, defaults_apply;
   wire ref_level, write_refused;
   wire [7:0] rd_data;
   int n_errors = 0, check_count = 0, n;
   always #12.5 clk = ~clk;
   arisq_host host_u (.*);
   arisq_sequencer #(.CAL_CYCLES(20)) dut_u (.*);
   task chk(input logic [7:0] g, e);
      check_count++;
      if (g !== e) begin n_errors++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end
   endtask
   task close_out;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Bounded wait for calibration end; fuse 4 plus calibration 20 plus a few cycles
   task idle;
      for (n = 0; n < 60 && busy !== 1'b0; n++) @(negedge clk);
      chk(8'(n >= 22 && n <= 30), 8'h01);
   endtask
   task wr(input logic [7:0] a, d);
      {wr_en, wr_addr, wr_data} = {1'b1, a, d};
      @(negedge clk);
      wr_en = 0;
   endtask
   // Read strobe for one cycle; data stands in the following cycle
   task rd(input logic [7:0] a, e);
      {rd_en, rd_addr} = {1'b1, a};
      @(negedge clk);
      rd_en = 0;
      chk(rd_data, e);
   endtask
   task t_hw;
      idle;
      host_u.hw_reset(1'b1);
      idle;
      chk(8'(ref_level), 8'h01);
      $display("hw reset done");
   endtask
   task t_busy;
      host_u.hw_reset(1'b0);
      wr(8'h00, 8'h01);
      chk(8'(write_refused), 8'h01);
      idle;
      chk(8'(ref_level), 8'h00);
      $display("refusal done");
   endtask
   task t_soft;
      wr(8'h05, 8'h01);
      repeat (3) @(negedge clk);
      chk(8'(defaults_apply), 8'h00);
      wr(8'h00, 8'h01);
      rd(8'h00, 8'h01);
      for (n = 0; n < 3 && defaults_apply !== 1'b1; n++) @(negedge clk);
      chk(8'(defaults_apply & busy), 8'h01);
      idle;
      rd(8'h00, 8'h00);
      rd(8'h05, 8'h00);
      $display("soft reset done");
   endtask
   initial begin
      repeat (6) @(negedge clk);
      rst = 0;
      t_hw;
      t_busy;
      t_soft;
      close_out;
   end
   // Watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #30000;
      n_errors++;
      close_out;
   end
endmodule

// [src/arisq_consts.vh]
`ifndef ARISQ_CONSTS_VH
`define ARISQ_CONSTS_VH
// Register map
`define ARISQ_SOFT_RESET_ADDR 8'h00
`define ARISQ_SOFT_RESET_BIT 0
`define ARISQ_SOFT_RESET_RST 8'h00
// Reset values of the status outputs
`define ARISQ_BUSY_RST 1'b1
`define ARISQ_APPLY_RST 1'b1
`define ARISQ_FLAG_RST 1'b0
// Calibration length in sampling-clock cycles
`define ARISQ_CAL_CYCLES 200000
// Fuse load length in cycles
`define ARISQ_FUSE_CYCLES 4
`endif

// [src/arisq_sequencer.v]
`timescale 1ns/10ps
`include "arisq_consts.vh"

// Functional notes
// - On reset release device loads fuse defaults, then calibrates about 200000 cycles.
// - Writing one to bit 0 at address global_soft_reset restores all register defaults.
// - Device clears the soft reset bit itself after defaults are restored.
// - Hardware and soft reset give identical default state at any time; here a soft reset write is ignored while busy is high.
module arisq_sequencer #(
   parameter CAL_CYCLES = `ARISQ_CAL_CYCLES,
   parameter FUSE_CYCLES = `ARISQ_FUSE_CYCLES
) (
   input wire clk,
   input wire rst,
   input wire reset_pin,
   input wire reference_config_pin,
   input wire serial_port_select,
   input wire wr_en,
   input wire [7:0] wr_addr,
   input wire [7:0] wr_data,
   input wire rd_en,
   input wire [7:0] rd_addr,
   output reg [7:0] rd_data,
   output reg busy,
   output reg fuse_load,
   output reg cal_run,
   output reg defaults_apply,
   output reg ref_level,
   output reg write_refused
);

////////////////////////////////////////////////////////////////////////
// Sequencer states; IDLE doubles as the state held during any reset
localparam ST_IDLE = 2'b00;
localparam ST_FUSE = 2'b01;
localparam ST_CAL = 2'b10;
localparam ST_READY = 2'b11;

// State and phase counter; 18 bits cover the default calibration length
reg [1:0] state_q;
reg [1:0] state_d;
reg [17:0] cnt_q;
reg [17:0] cnt_d;
// Self-clearing soft reset bit of the control register
reg soft_bit_q;
reg soft_bit_d;
// Decoded requests and terminal counts
wire soft_req;
wire pin_reset;
wire any_reset;
wire [17:0] fuse_end;
wire [17:0] cal_end;
wire fuse_last;
wire cal_last;

////////////////////////////////////////////////////////////////////////
// Request decode
// A soft reset is honoured only once calibration is over, so a stray
// write during start-up cannot restart the count from zero
assign soft_req = wr_en && !busy && (wr_addr == `ARISQ_SOFT_RESET_ADDR)
                  && wr_data[`ARISQ_SOFT_RESET_BIT];
// The pin acts exactly like the power-on reset for sequencing
assign pin_reset = rst || reset_pin;
// Both reset sources feed one path so the resulting state is the same
assign any_reset = pin_reset || soft_bit_q;

// Terminal counts of the two timed phases; counts above 18 bits wrap
assign fuse_end = FUSE_CYCLES[17:0] - 18'h0_0001;
assign cal_end = CAL_CYCLES[17:0] - 18'h0_0001;
assign fuse_last = (cnt_q == fuse_end);
assign cal_last = (cnt_q == cal_end);

////////////////////////////////////////////////////////////////////////
// Soft reset bit: set by a write, cleared by hardware one cycle later
always @* begin
   soft_bit_d = soft_bit_q;
   if (pin_reset) begin
      // Hardware reset beats the soft bit
      soft_bit_d = 1'b0;
   end else if (soft_req) begin
      soft_bit_d = 1'b1;
   end else if (soft_bit_q) begin
      soft_bit_d = 1'b0; // Self-clear once defaults are applied
   end
end

// Soft bit register; its reset comes through the next-value logic
always @(posedge clk) begin
   soft_bit_q <= soft_bit_d;
end

////////////////////////////////////////////////////////////////////////
// Next state: fuse load, then calibration, after any reset release
always @* begin
   state_d = state_q;
   cnt_d = cnt_q;
   if (any_reset) begin
      state_d = ST_IDLE;
      cnt_d = 18'h0_0000;
   end else begin
      case (state_q)
         ST_IDLE: begin
            // Defaults are loaded first, calibration follows
            state_d = ST_FUSE;
            cnt_d = 18'h0_0000;
         end
         ST_FUSE: begin
            if (fuse_last) begin
               state_d = ST_CAL;
               cnt_d = 18'h0_0000;
            end else begin
               cnt_d = cnt_q + 18'h0_0001;
            end
         end
         ST_CAL: begin
            // Count sampling-clock cycles of the calibration
            if (cal_last) begin
               state_d = ST_READY;
               cnt_d = 18'h0_0000;
            end else begin
               cnt_d = cnt_q + 18'h0_0001;
            end
         end
         ST_READY: begin
            state_d = ST_READY;
            cnt_d = 18'h0_0000;
         end
         default: begin
            state_d = ST_IDLE;
            cnt_d = 18'h0_0000;
         end
      endcase
   end
end

// State and counter registers
always @(posedge clk) begin
   state_q <= state_d;
   cnt_q <= cnt_d;
end

////////////////////////////////////////////////////////////////////////
// Busy covers reset, fuse load and calibration, so writes can be gated
always @(posedge clk) begin
   if (rst) begin
      busy <= `ARISQ_BUSY_RST;
   end else begin
      busy <= any_reset || (state_q != ST_READY);
   end
end

// Fuse load phase indicator
always @(posedge clk) begin
   if (rst) begin
      fuse_load <= `ARISQ_FLAG_RST;
   end else begin
      fuse_load <= !any_reset && (state_q == ST_FUSE);
   end
end

// Calibration phase indicator
always @(posedge clk) begin
   if (rst) begin
      cal_run <= `ARISQ_FLAG_RST;
   end else begin
      cal_run <= !any_reset && (state_q == ST_CAL);
   end
end

// Defaults are forced while any reset source is active
always @(posedge clk) begin
   if (rst) begin
      defaults_apply <= `ARISQ_APPLY_RST;
   end else begin
      defaults_apply <= any_reset;
   end
end

////////////////////////////////////////////////////////////////////////
// Reference strap is sampled while the pin holds the block in reset;
// a strap changed later is not seen until the next pin reset
always @(posedge clk) begin
   if (rst) begin
      ref_level <= `ARISQ_FLAG_RST;
   end else if (reset_pin) begin
      ref_level <= reference_config_pin;
   end
end

// Writes during calibration are dropped, and flagged for one cycle
always @(posedge clk) begin
   if (rst) begin
      write_refused <= `ARISQ_FLAG_RST;
   end else begin
      write_refused <= wr_en && busy;
   end
end

////////////////////////////////////////////////////////////////////////
// Read-back of the control register; zero when no read is made
always @(posedge clk) begin
   if (rst) begin
      rd_data <= `ARISQ_SOFT_RESET_RST;
   end else if (rd_en && (rd_addr == `ARISQ_SOFT_RESET_ADDR)) begin
      rd_data <= {7'h00, soft_bit_q}; // Shows the self-clear
   end else begin
      rd_data <= 8'h00;
   end
end

endmodule
